// ==== design/iwd_pkg.sv ====
package iwd_pkg;

  // ************************************************************
  // Host port decode
  // ************************************************************
  localparam logic [15:0] PORT_INDEX = 16'h002e;  // Index (address) port.
  localparam logic [15:0] PORT_DATA  = 16'h002f;  // Data port.

  // ************************************************************
  // Keys, indices and bank
  // ************************************************************
  localparam logic [7:0] KEY_UNLOCK = 8'h87;  // Written twice to open.
  localparam logic [7:0] KEY_LOCK   = 8'haa;  // Written once to close.
  localparam logic [7:0] REG_BANK   = 8'h07;  // bank_select index.
  localparam logic [7:0] REG_ACT    = 8'h30;  // watchdog_activate index.
  localparam logic [7:0] REG_UNIT   = 8'hf5;  // count_unit_config index.
  localparam logic [7:0] REG_COUNT  = 8'hf6;  // timeout_count index.
  localparam logic [7:0] REG_CTRL   = 8'hf7;  // control/status index.
  localparam logic [7:0] BANK_WDT   = 8'h08;  // Bank that holds the timer.
  localparam logic [7:0] ACT_ON     = 8'h01;  // Activation value.
  localparam logic [7:0] READ_IDLE  = 8'hff;  // Read answer while locked.
  localparam logic [7:0] READ_NONE  = 8'h00;  // Read of an empty index.

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int UNIT_MIN_BIT  = 3;  // 0 seconds, 1 minutes.
  localparam int UNIT_FAST_BIT = 4;  // Thousand times faster.
  localparam int CTRL_MOUSE    = 7;  // Mouse activity restarts.
  localparam int CTRL_KBD      = 6;  // Keyboard activity restarts.
  localparam int CTRL_FORCE    = 5;  // Force timeout, self clearing.
  localparam int CTRL_STATUS   = 4;  // Timeout seen, read only.
  localparam logic [7:0] RST_REG = 8'h00;  // Reset of every register.

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 8;        // 125 MHz clock.
  localparam int MS_NS         = 1000000;  // One millisecond in ns.
  localparam int DIV_W         = 17;       // Divider counter width.
  localparam logic [DIV_W-1:0] CYC_PER_MS =
    DIV_W'(MS_NS / CLK_PERIOD_NS);
  // Unit lengths counted in millisecond ticks.
  localparam logic [DIV_W-1:0] LIM_MS   = 17'h00001;  // 1 ms.
  localparam logic [DIV_W-1:0] LIM_MMIN = 17'h0003c;  // 60 ms.
  localparam logic [DIV_W-1:0] LIM_SEC  = 17'h003e8;  // 1000 ms.
  localparam logic [DIV_W-1:0] LIM_MIN  = 17'h0ea60;  // 60000 ms.

  // ************************************************************
  // Types
  // ************************************************************
  // Key sequence state, one-hot.
  typedef enum logic [2:0] {
    IWD_LOCKED = 3'b001,
    IWD_HALF   = 3'b010,
    IWD_OPEN   = 3'b100
  } iwd_key_t;

  // One host I/O cycle, valid for one clock.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } iwd_io_req_t;

  // Whole state of the watchdog top.
  typedef struct packed {
    iwd_key_t   key;
    logic [7:0] index;
    logic [7:0] bank;
    logic [7:0] act;
    logic [7:0] unit;
    logic [7:0] count;
    logic       mouse_en;
    logic       kbd_en;
    logic       status;
    logic [7:0] cnt;
    logic [7:0] rdata;
    logic       timeout;
  } iwd_state_t;

  // Whole state of a divider.
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } iwd_div_state_t;

endpackage

// ==== design/iwd_div.sv ====
`timescale 1ns/1ps

// ************************************************************
// Restartable divider producing a one-cycle tick
// ************************************************************
module iwd_div (
  // Clock and reset.
  input  wire logic                      clock,
  input  wire logic                      nrst,
  // Control.
  input  wire logic                      restart,
  input  wire logic                      en,
  input  wire logic [iwd_pkg::DIV_W-1:0] limit,
  // Output tick.
  output logic                           tick
);

  iwd_pkg::iwd_div_state_t s_r;    // Registered state.
  iwd_pkg::iwd_div_state_t s_nxt;  // Next state.

  // Count enabled cycles; wrap and tick after limit of them.
  // A restart realigns the phase so a fresh unit is always whole.
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (restart)
    begin
      s_nxt.cnt = '0;
    end
    else if (en)
    begin
      if (s_r.cnt >= iwd_pkg::DIV_W'(limit - 17'h1))
      begin
        s_nxt.cnt  = '0;
        s_nxt.tick = 1'b1;
      end
      else
      begin
        s_nxt.cnt = iwd_pkg::DIV_W'(s_r.cnt + 17'h1);
      end
    end
  end

  // State register.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;

endmodule

// ==== design/iwd_top.sv ====
`timescale 1ns/1ps

// Notes on behaviour
// - Index port selects, data port transfers.
// - Two consecutive unlock key writes open access.
// - Lock key closes; data writes then ignored.
// - Bank value routes accesses to watchdog bank.
// - Timer active only when activation holds 01.
// - Unit bit 3 picks seconds or minutes.
// - Unit bit 4 makes ticks thousand times faster.
// - Count zero stops; 01 to FF units.
// - Expiry without restart asserts timeout output.
// - Count write reloads and restarts counter.
// - Keyboard enable bit lets keystrokes restart timer.
// - Force bit gives immediate timeout, self clears.
// - Status bit reads one after expiry.
// - Mouse enable bit lets mouse restart timer.

module iwd_top #(
  // Clock cycles in one millisecond; shorten for simulation.
  parameter logic [iwd_pkg::DIV_W-1:0] CYC_PER_MS = iwd_pkg::CYC_PER_MS
) (
  // Clock and reset.
  input  wire logic                 clock,
  input  wire logic                 nrst,
  // Host I/O port cycle.
  input  wire iwd_pkg::iwd_io_req_t io_req,
  output logic [7:0]                io_rdata,
  // Activity that may restart the timer.
  input  wire logic                 kbd_activity,
  input  wire logic                 mouse_activity,
  // Watchdog results.
  output logic                      wdt_timeout,
  output logic                      wdt_status
);

  // ************************************************************
  // State and decode
  // ************************************************************
  iwd_pkg::iwd_state_t     s_r;       // Registered state.
  iwd_pkg::iwd_state_t     s_nxt;     // Next state.
  logic                    ms_tick;   // One pulse per millisecond.
  logic                    unit_tick; // One pulse per counting unit.
  logic                    reload;    // Counter reloads this cycle.
  logic                    running;   // Counter may decrement.
  logic [iwd_pkg::DIV_W-1:0] unit_lim; // Milliseconds per unit.
  logic                    idx_wr;    // Index port write.
  logic                    dat_wr;    // Data port write.
  logic                    dat_rd;    // Data port read.
  logic                    idx_rd;    // Index port read.
  logic                    open;      // Configuration is unlocked.
  logic                    in_bank;   // Watchdog bank selected.
  logic                    cnt_wr;    // Write to the count register.
  logic                    force_wr;  // Write of the force bit.
  logic                    act_hit;   // Activity restart request.

  // Port decode. The index port takes an address, the data port
  // then moves the byte of whichever register was last indexed.
  always_comb
  begin
    idx_wr  = io_req.wr && (io_req.addr == iwd_pkg::PORT_INDEX);
    dat_wr  = io_req.wr && (io_req.addr == iwd_pkg::PORT_DATA);
    idx_rd  = io_req.rd && (io_req.addr == iwd_pkg::PORT_INDEX);
    dat_rd  = io_req.rd && (io_req.addr == iwd_pkg::PORT_DATA);
    open    = (s_r.key == iwd_pkg::IWD_OPEN);
    in_bank = (s_r.bank == iwd_pkg::BANK_WDT);
    cnt_wr  = dat_wr && open && in_bank &&
              (s_r.index == iwd_pkg::REG_COUNT);
    force_wr = dat_wr && open && in_bank &&
               (s_r.index == iwd_pkg::REG_CTRL) &&
               io_req.wdata[iwd_pkg::CTRL_FORCE];
  end

  // ************************************************************
  // Unit selection and dividers
  // ************************************************************
  // Pick the unit length in milliseconds from the unit register.
  always_comb
  begin
    unique case ({s_r.unit[iwd_pkg::UNIT_FAST_BIT],
                  s_r.unit[iwd_pkg::UNIT_MIN_BIT]})
      2'b00:   unit_lim = iwd_pkg::LIM_SEC;
      2'b01:   unit_lim = iwd_pkg::LIM_MIN;
      2'b10:   unit_lim = iwd_pkg::LIM_MS;
      default: unit_lim = iwd_pkg::LIM_MMIN;
    endcase
  end

  // Counting needs activation and a nonzero count.
  assign running = (s_r.act == iwd_pkg::ACT_ON) && (s_r.cnt != '0);
  // Either enabled source restarts an active, programmed timer.
  assign act_hit = (s_r.act == iwd_pkg::ACT_ON) &&
                   (s_r.count != '0) &&
                   ((s_r.kbd_en && kbd_activity) ||
                    (s_r.mouse_en && mouse_activity));
  assign reload = cnt_wr || act_hit;

  // Millisecond prescaler. Both dividers restart on reload so a
  // reload always grants one full unit before the first decrement.
  iwd_div u_ms_div (
    .clock   (clock),
    .nrst    (nrst),
    .restart (reload),
    .en      (running),
    .limit   (CYC_PER_MS),
    .tick    (ms_tick)
  );

  // Unit divider counts milliseconds into the selected unit.
  iwd_div u_unit_div (
    .clock   (clock),
    .nrst    (nrst),
    .restart (reload),
    .en      (running && ms_tick),
    .limit   (unit_lim),
    .tick    (unit_tick)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  // Key sequence, register writes, read answers and the counter.
  always_comb
  begin
    s_nxt         = s_r;
    s_nxt.timeout = 1'b0;

    // Key sequence on the index port. Any other write between the
    // two unlock keys starts the sequence over.
    unique case (s_r.key)
      iwd_pkg::IWD_LOCKED:
      begin
        if (idx_wr && io_req.wdata == iwd_pkg::KEY_UNLOCK)
          s_nxt.key = iwd_pkg::IWD_HALF;
      end
      iwd_pkg::IWD_HALF:
      begin
        if (idx_wr && io_req.wdata == iwd_pkg::KEY_UNLOCK)
          s_nxt.key = iwd_pkg::IWD_OPEN;
        else if (io_req.wr)
          s_nxt.key = iwd_pkg::IWD_LOCKED;
      end
      iwd_pkg::IWD_OPEN:
      begin
        if (idx_wr && io_req.wdata == iwd_pkg::KEY_LOCK)
          s_nxt.key = iwd_pkg::IWD_LOCKED;
        else if (idx_wr)
          s_nxt.index = io_req.wdata;
      end
      default: s_nxt.key = iwd_pkg::IWD_LOCKED;
    endcase

    // Data port writes take effect only while open. The bank
    // select is always reachable; the timer needs the timer bank.
    if (dat_wr && open)
    begin
      if (s_r.index == iwd_pkg::REG_BANK)
        s_nxt.bank = io_req.wdata;
      else if (in_bank)
      begin
        unique case (s_r.index)
          iwd_pkg::REG_ACT:   s_nxt.act = io_req.wdata;
          iwd_pkg::REG_UNIT:  s_nxt.unit = io_req.wdata;
          iwd_pkg::REG_COUNT: s_nxt.count = io_req.wdata;
          iwd_pkg::REG_CTRL:
          begin
            s_nxt.mouse_en = io_req.wdata[iwd_pkg::CTRL_MOUSE];
            s_nxt.kbd_en   = io_req.wdata[iwd_pkg::CTRL_KBD];
          end
          default: s_nxt.act = s_r.act;
        endcase
      end
    end

    // Read answers appear one clock after the read strobe.
    if (dat_rd || idx_rd)
    begin
      if (!open)
        s_nxt.rdata = iwd_pkg::READ_IDLE;
      else if (idx_rd)
        s_nxt.rdata = s_r.index;
      else if (s_r.index == iwd_pkg::REG_BANK)
        s_nxt.rdata = s_r.bank;
      else if (!in_bank)
        s_nxt.rdata = iwd_pkg::READ_NONE;
      else
      begin
        unique case (s_r.index)
          iwd_pkg::REG_ACT:   s_nxt.rdata = s_r.act;
          iwd_pkg::REG_UNIT:  s_nxt.rdata = s_r.unit;
          iwd_pkg::REG_COUNT: s_nxt.rdata = s_r.count;
          // The force bit always reads back as zero, since it
          // is not held in any register; a write acts in its own cycle only.
          iwd_pkg::REG_CTRL:
          begin
            s_nxt.rdata = iwd_pkg::READ_NONE;
            s_nxt.rdata[iwd_pkg::CTRL_MOUSE]  = s_r.mouse_en;
            s_nxt.rdata[iwd_pkg::CTRL_KBD]    = s_r.kbd_en;
            s_nxt.rdata[iwd_pkg::CTRL_STATUS] = s_r.status;
          end
          default:            s_nxt.rdata = iwd_pkg::READ_NONE;
        endcase
      end
    end

    // Counter. A count write loads the new value, an activity
    // restart the programmed one; zero leaves the timer stopped.
    if (cnt_wr)
    begin
      s_nxt.cnt    = io_req.wdata;
      s_nxt.status = 1'b0;
    end
    else if (act_hit)
      s_nxt.cnt = s_r.count;
    else if (running && unit_tick)
    begin
      s_nxt.cnt = 8'(s_r.cnt - 8'h01);
      if (s_r.cnt == 8'h01)
      begin
        s_nxt.timeout = 1'b1;
        s_nxt.status  = 1'b1;
      end
    end

    // Forced timeout; placed last so a set beats a same-cycle clear.
    if (force_wr)
    begin
      s_nxt.timeout = 1'b1;
      s_nxt.status  = 1'b1;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // Reset leaves the ports locked and the timer inactive.
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r       <= '0;
      s_r.key   <= iwd_pkg::IWD_LOCKED;
      s_r.rdata <= iwd_pkg::READ_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign io_rdata    = s_r.rdata;
  assign wdt_timeout = s_r.timeout;
  assign wdt_status  = s_r.status;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  AST_UNLOCK_PAIR: assert property (
    s_r.key == iwd_pkg::IWD_HALF && idx_wr &&
    io_req.wdata == iwd_pkg::KEY_UNLOCK |=> open)
    else $error("second unlock key did not open access");

  AST_BROKEN_PAIR: assert property (
    s_r.key == iwd_pkg::IWD_HALF && dat_wr |=>
    s_r.key == iwd_pkg::IWD_LOCKED)
    else $error("unlock survived an intervening write");

  AST_LOCK_HOLDS: assert property (
    !open && dat_wr |=> $stable(s_r.count) && $stable(s_r.act))
    else $error("locked data write changed configuration");

  AST_BANK_GUARD: assert property (
    open && !in_bank && dat_wr &&
    s_r.index == iwd_pkg::REG_COUNT |=> $stable(s_r.count))
    else $error("count written outside the watchdog bank");

  AST_RELOAD: assert property (
    cnt_wr |=> s_r.cnt == $past(io_req.wdata) && !s_r.status)
    else $error("count write did not reload the counter");

  AST_INACTIVE: assert property (
    s_r.act != iwd_pkg::ACT_ON && !cnt_wr |=> $stable(s_r.cnt))
    else $error("counter moved while inactive");

  AST_EXPIRE: assert property (
    running && unit_tick && s_r.cnt == 8'h01 && !reload |=>
    wdt_timeout && wdt_status && s_r.cnt == '0 ##1
    (!wdt_timeout || $past(force_wr)))
    else $error("expiry did not give a one-cycle timeout");

  AST_FORCE: assert property (
    force_wr |=> wdt_timeout && wdt_status)
    else $error("forced timeout missing");

  AST_KBD_RESTART: assert property (
    act_hit && !cnt_wr |=> s_r.cnt == $past(s_r.count))
    else $error("activity did not restart the counter");

  AST_STATUS_STICKY: assert property (
    wdt_status && !cnt_wr |=> wdt_status)
    else $error("timeout status cleared without count write");

  AST_UNIT_SEC: assert property (
    s_r.unit[iwd_pkg::UNIT_FAST_BIT:iwd_pkg::UNIT_MIN_BIT] == 2'b00
    |-> unit_lim == iwd_pkg::LIM_SEC)
    else $error("seconds unit not selected");

  // Counter and pulse checks. A timeout may only come from an expiry
  // or a forced write, so a stray tick cannot reset the host.
  AST_STOPPED: assert property (
    s_r.cnt == '0 && !reload |=> s_r.cnt == '0)
    else $error("stopped counter moved without a reload");

  AST_STEP: assert property (
    running && unit_tick && !reload |=>
    s_r.cnt == 8'($past(s_r.cnt) - 8'h01))
    else $error("unit tick did not take one from the counter");

  AST_TIMEOUT_CAUSE: assert property (
    wdt_timeout |->
    $past(force_wr) || ($past(s_r.cnt) == 8'h01 && s_r.cnt == '0))
    else $error("timeout pulse without expiry or force");

  // Read path and locked index checks.
  AST_LOCKED_READ: assert property (
    !open && (dat_rd || idx_rd) |=> io_rdata == iwd_pkg::READ_IDLE)
    else $error("locked read did not return the idle value");

  AST_CTRL_READ: assert property (
    open && in_bank && dat_rd && s_r.index == iwd_pkg::REG_CTRL |=>
    io_rdata[iwd_pkg::CTRL_STATUS] == $past(s_r.status) &&
    !io_rdata[iwd_pkg::CTRL_FORCE])
    else $error("control read lost status or showed the force bit");

  AST_INDEX_LOCKED: assert property (
    !open && idx_wr |=> $stable(s_r.index))
    else $error("index changed while locked");

  COV_EXPIRE: cover property (running ##1 wdt_timeout);
  COV_FORCE: cover property (force_wr ##1 wdt_timeout);
  COV_RESTART: cover property (act_hit ##1 running);
  COV_LOCK: cover property (open ##1 !open);
  COV_MMIN: cover property (running && unit_tick &&
    s_r.unit[iwd_pkg::UNIT_FAST_BIT] && s_r.unit[iwd_pkg::UNIT_MIN_BIT]);

endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps

// ************************************************************
// Self-checking bench for the indexed watchdog
// ************************************************************
module tb_top;
  localparam logic [16:0] CPM = 17'h00004;  // Short ms keeps runs brief.
  localparam int MSC = 4;                   // Cycles in one ms unit.
  localparam int LIMIT = 20000;             // Ceiling on the run.
  localparam logic [7:0] UNITS [3] = '{8'h10, 8'h18, 8'h00};
  localparam int LIMS [3] = '{MSC, 60 * MSC, 1000 * MSC};

  // Expected window, in cycles, of one timeout pulse.
  typedef struct {int lo; int hi;} iwd_tb_win_t;

  logic                 clock = 1'b0;     // System clock.
  logic                 nrst = 1'b0;      // Reset, active low.
  iwd_pkg::iwd_io_req_t io_req = '0;      // Host cycle.
  logic                 kbd_activity = 1'b0;
  logic                 mouse_activity = 1'b0;
  logic [7:0]           io_rdata;
  logic                 wdt_timeout;
  logic                 wdt_status;
  int                   cyc = 0;          // Rising edges so far.
  int                   bad_count = 0;
  int                   n_checks = 0;
  int                   e;                // Cycle after last host cycle or activity pulse.
  logic                 rd_d1 = 1'b0;     // Read strobe, delayed.
  logic                 rd_d2 = 1'b0;
  logic [7:0]           rq [$];           // Expected read answers.
  iwd_tb_win_t          tq [$];           // Expected timeout pulses.

  always #4 clock = ~clock;

  iwd_top #(.CYC_PER_MS(CPM)) uut (
    .clock          (clock),
    .nrst           (nrst),
    .io_req         (io_req),
    .io_rdata       (io_rdata),
    .kbd_activity   (kbd_activity),
    .mouse_activity (mouse_activity),
    .wdt_timeout    (wdt_timeout),
    .wdt_status     (wdt_status)
  );

  // Cycle count, read delay line and the hang guard.
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    rd_d1 <= io_req.rd;
    rd_d2 <= rd_d1;
    if (cyc >= LIMIT)
    begin
      bad_count = bad_count + 1;
      conclude();
    end
  end

  // Watcher: a result appearing takes the oldest note off its queue.
  // Any pulse with no note pending counts as a mismatch.
  always @(negedge clock)
  begin
    if (rd_d2)
      chk_rd();
    if (wdt_timeout === 1'b1)
      chk_to();
  end

  // Counts one comparison and reports a mismatch.
  task automatic note(input logic ok, input logic [31:0] got,
                      input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (ok !== 1'b1)
    begin
      bad_count = bad_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Compares one flag.
  task automatic chk(input logic got, input logic exp);
    note(got === exp, 32'(got), 32'(exp));
  endtask

  // Compares one byte.
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp, 32'(got), 32'(exp));
  endtask

  // Read answer against the oldest note; unknown if none was noted.
  task automatic chk_rd();
    logic [7:0] x;
    x = 8'hxx;
    if (rq.size() > 0)
      x = rq.pop_front();
    chk8(io_rdata, x);
  endtask

  // Timeout pulse must land inside the oldest noted window.
  task automatic chk_to();
    iwd_tb_win_t w;
    w = '{-1, -1};
    if (tq.size() > 0)
      w = tq.pop_front();
    note(cyc >= w.lo && cyc <= w.hi, 32'(cyc), 32'(w.lo));
  endtask

  // One host cycle; the idle cycle after it keeps strobes single.
  task automatic put(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    @(negedge clock);
    io_req = '{wr: w, rd: ~w, addr: a, wdata: d};
    @(negedge clock);
    e = cyc;
    io_req = '0;
  endtask

  // Index write followed by a data write.
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    put(1'b1, iwd_pkg::PORT_INDEX, i);
    put(1'b1, iwd_pkg::PORT_DATA, d);
  endtask

  // Index write followed by a data read with its expected answer.
  task automatic rd(input logic [7:0] i, input logic [7:0] x);
    put(1'b1, iwd_pkg::PORT_INDEX, i);
    rq.push_back(x);
    put(1'b0, iwd_pkg::PORT_DATA, 8'h00);
  endtask

  // Two adjacent key writes.
  task automatic unlock();
    put(1'b1, iwd_pkg::PORT_INDEX, iwd_pkg::KEY_UNLOCK);
    put(1'b1, iwd_pkg::PORT_INDEX, iwd_pkg::KEY_UNLOCK);
  endtask

  // Loads the count and notes when expiry is due.
  task automatic arm(input int lim, input logic [7:0] n);
    wr(iwd_pkg::REG_COUNT, n);
    tq.push_back('{e + lim * int'(n), e + lim * int'(n) + 8});
  endtask

  // Waits a fixed time; every noted result must have arrived by then.
  task automatic settle(input int n, input string name);
    repeat (n) @(negedge clock);
    note(tq.size() == 0 && rq.size() == 0, 32'(tq.size()), 32'h0);
    $display("test %s done", name);
  endtask

  // Prints counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    logic [7:0] n;
    logic [7:0] c;
    void'($urandom(32'hcb37));
    repeat (12) @(negedge clock);
    chk8(io_rdata, iwd_pkg::READ_IDLE);
    chk(wdt_timeout, 1'b0);
    chk(wdt_status, 1'b0);
    nrst = 1'b1;
    // A data write between the keys must break the sequence.
    rd(iwd_pkg::REG_COUNT, iwd_pkg::READ_IDLE);
    put(1'b1, iwd_pkg::PORT_INDEX, iwd_pkg::KEY_UNLOCK);
    put(1'b1, iwd_pkg::PORT_DATA, iwd_pkg::BANK_WDT);
    put(1'b1, iwd_pkg::PORT_INDEX, iwd_pkg::KEY_UNLOCK);
    rd(iwd_pkg::REG_BANK, iwd_pkg::READ_IDLE);
    unlock();
    wr(iwd_pkg::REG_COUNT, 8'h05);
    rd(iwd_pkg::REG_COUNT, iwd_pkg::READ_NONE);
    rd(8'h55, iwd_pkg::READ_NONE);
    put(1'b1, 16'h0080, 8'h5a);
    wr(iwd_pkg::REG_BANK, iwd_pkg::BANK_WDT);
    rd(iwd_pkg::REG_BANK, iwd_pkg::BANK_WDT);
    rd(iwd_pkg::REG_COUNT, iwd_pkg::RST_REG);
    rd(iwd_pkg::REG_UNIT, iwd_pkg::RST_REG);
    rd(iwd_pkg::REG_CTRL, iwd_pkg::RST_REG);
    rd(iwd_pkg::REG_ACT, iwd_pkg::RST_REG);
    settle(10, "access");
    // Timer stays frozen until activated, then expires.
    wr(iwd_pkg::REG_UNIT, 8'h10);
    wr(iwd_pkg::REG_COUNT, 8'h02);
    settle(40, "inactive");
    wr(iwd_pkg::REG_ACT, iwd_pkg::ACT_ON);
    tq.push_back('{e + 4, e + 16});
    settle(30, "activate");
    chk(wdt_status, 1'b1);
    rd(iwd_pkg::REG_CTRL, 8'h10);
    settle(40, "stopped");
    chk(wdt_status, 1'b1);
    // Three units: ms, milli-minute and seconds.
    for (int k = 0; k < 3; k++)
    begin
      n = 8'(2 + $urandom % 3);
      wr(iwd_pkg::REG_UNIT, UNITS[k]);
      arm(LIMS[k], n);
      chk(wdt_status, 1'b0);
      settle(LIMS[k] * int'(n) + 20, "unit");
    end
    // A rewrite of the count restarts from the new value.
    wr(iwd_pkg::REG_UNIT, 8'h10);
    wr(iwd_pkg::REG_COUNT, 8'h03);
    repeat (8) @(negedge clock);
    arm(MSC, 8'h03);
    settle(30, "reload");
    // Activity restarts only when its enable bit is set.
    for (int k = 0; k < 3; k++)
    begin
      c = (k == 0) ? 8'h40 : (k == 1) ? 8'h80 : 8'h00;
      wr(iwd_pkg::REG_CTRL, c);
      wr(iwd_pkg::REG_COUNT, 8'h04);
      if (c == 8'h00)
        tq.push_back('{e + 4 * MSC, e + 4 * MSC + 8});
      rd(iwd_pkg::REG_CTRL, c);
      repeat (5)
      begin
        @(negedge clock);
        kbd_activity = (c != 8'h80);
        mouse_activity = (c != 8'h40);
        @(negedge clock);
        e = cyc;
        kbd_activity = 1'b0;
        mouse_activity = 1'b0;
        repeat (4 + $urandom % 5) @(negedge clock);
      end
      if (c != 8'h00)
        tq.push_back('{e + 4 * MSC, e + 4 * MSC + 8});
      settle(40, "activity");
    end
    // Forced timeout works while inactive and the bit self clears.
    wr(iwd_pkg::REG_ACT, 8'h00);
    wr(iwd_pkg::REG_COUNT, 8'h04);
    chk(wdt_status, 1'b0);
    wr(iwd_pkg::REG_CTRL, 8'h20);
    tq.push_back('{e, e + 3});
    settle(10, "force");
    chk(wdt_status, 1'b1);
    rd(iwd_pkg::REG_CTRL, 8'h10);
    // Once locked, data writes are ignored and reads are idle.
    put(1'b1, iwd_pkg::PORT_INDEX, iwd_pkg::KEY_LOCK);
    wr(iwd_pkg::REG_COUNT, 8'h07);
    rd(iwd_pkg::REG_COUNT, iwd_pkg::READ_IDLE);
    unlock();
    rd(iwd_pkg::REG_COUNT, 8'h04);
    settle(10, "lock");
    // A device reset mid-run clears the sticky status and relocks.
    chk(wdt_status, 1'b1);
    nrst = 1'b0;
    repeat (2) @(negedge clock);
    chk(wdt_status, 1'b0);
    chk8(io_rdata, iwd_pkg::READ_IDLE);
    nrst = 1'b1;
    rd(iwd_pkg::REG_BANK, iwd_pkg::READ_IDLE);
    settle(10, "reset");
    conclude();
  end
endmodule
